// ==== hdl/ebr_pkg.sv ====
// package of constants and carrier types for the external bus refresh control block
// How it works
// - bank-0 mode bit picks lane enables or strobes
// - refresh enable starts periodic auto-refresh, clear stops
// - mode bit 1 puts SDRAM in self-refresh
// - any SDRAM access clears self-refresh mode bit
// - clock control bit drives CKE outside self-refresh (held low there), defaults one
// - one refresh per interval count of clocks
// - wait request sampled at cycle two to four
// - endian bit holds strap sampled at reset
package ebr_pkg;
  // register byte offset on the bus
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  // field positions
  localparam int          LANE_MODE_BIT     = 24;
  localparam int          REF_EN_BIT        = 18;
  localparam int          REF_MODE_BIT      = 17;
  localparam int          CKE_BIT           = 16;
  localparam int          REF_CNT_LSB       = 3;
  localparam int          REF_CNT_W         = 13;
  localparam int          WAIT_SEL_LSB      = 1;
  localparam int          ENDIAN_BIT        = 0;
  // writable bit mask (reserved and read-only bits excluded)
  localparam logic [31:0] WRITE_MASK        = 32'h0107_FFFE;
  // reset value of the register fields
  localparam logic [31:0] CTRL_RESET        = 32'h0001_0000;
  // refresh command pulse length in clocks
  localparam logic [3:0]  REF_PULSE_CYCLES  = 4'h1;

  // external access request carrier
  typedef struct packed {
    logic       strobe;     // access strobe active
    logic       is_sdram;   // access targets SDRAM
    logic       is_write;   // write access
    logic [1:0] lanes;      // byte lanes accessed
  } ebr_access_t;

  // byte lane pin carrier
  typedef struct packed {
    logic [1:0] lane_n;     // lane strobes, active low
    logic       we_n;       // write strobe, active low
  } ebr_lanes_t;
endpackage

// ==== hdl/ebr_wait_sampler.sv ====
// wait request sampler for external accesses
`timescale 1ns/1ns
module ebr_wait_sampler (
  input  wire logic       clk_i,        // system clock
  input  wire logic       rst_i,        // synchronous reset
  input  wire logic       strobe_i,     // access strobe active
  input  wire logic [1:0] wait_sel_i,   // sample cycle select
  input  wire logic       wait_n_i,     // synchronised wait request
  output logic            sample_o,     // pulse at sample cycle
  output logic            waiting_o     // wait was seen low there
);
  logic [2:0] cnt_reg;                  // cycles since strobe rose
  logic       prev_strobe_reg;          // strobe one cycle ago
  logic [2:0] target;                   // nth cycle wanted

  // map select code to cycle number
  always_comb begin
    case (wait_sel_i)
      2'h1:    target = 3'h2;
      2'h2:    target = 3'h3;
      2'h3:    target = 3'h4;
      default: target = 3'h0;           // sampling off
    endcase
  end

  // count cycles from strobe start
  always_ff @(posedge clk_i) begin
    if (rst_i || !strobe_i) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != 3'h7) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_strobe_reg <= 1'b0;
    end else begin
      prev_strobe_reg <= strobe_i;
    end
  end

  // sample pulse and captured wait level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_o  <= 1'b0;
      waiting_o <= 1'b0;
    end else begin
      sample_o <= 1'b0;
      if (strobe_i && target != 3'h0 && cnt_reg == target - 3'h1) begin
        sample_o  <= 1'b1;
        waiting_o <= !wait_n_i;
      end else if (!strobe_i) begin
        waiting_o <= 1'b0;
      end
    end
  end

  sample_at_n_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(strobe_i) && wait_sel_i == 2'h1 ##1 strobe_i |=> sample_o)
    else $error("wait not sampled at second cycle");
endmodule

// ==== hdl/ebr_ctrl.sv ====
// external bus control register with refresh, CKE, lane and wait logic
`timescale 1ns/1ns
module ebr_ctrl (
  input  wire logic        clk_i,          // system clock
  input  wire logic        rst_i,          // synchronous reset
  // wishbone slave
  input  wire logic        wb_cyc_i,       // bus cycle
  input  wire logic        wb_stb_i,       // strobe
  input  wire logic        wb_we_i,        // write
  input  wire logic [7:0]  wb_adr_i,       // byte address
  input  wire logic [3:0]  wb_sel_i,       // byte selects
  input  wire logic [31:0] wb_dat_i,       // write data
  output logic [31:0]      wb_dat_o,       // read data
  output logic             wb_ack_o,       // acknowledge
  output logic             wb_err_o,       // unmapped address
  // external access side
  input  wire logic        acc_strobe_i,   // access strobe
  input  wire logic        acc_sdram_i,    // access targets SDRAM
  input  wire logic        acc_write_i,    // write access
  input  wire logic [1:0]  acc_lanes_i,    // lanes accessed
  input  wire logic        ext_wait_request_n_i, // pin, active low
  input  wire logic        endian_strap_line_i,  // strap pin
  // outputs
  output logic [1:0]       byte_lane_strobe_n_o, // lane pins
  output logic             write_strobe_n_o,     // write strobe pin
  output logic             sdram_cke_o,          // SDRAM CKE
  output logic             refresh_req_o,        // auto-refresh pulse
  output logic             self_refresh_o,       // self-refresh held
  output logic             wait_stall_o          // access stretched
);
  ////////////////////////////////////////////////////////////
  // register fields
  logic                  lane_mode_reg;    // bank-0 lane mode
  logic                  ref_en_reg;       // refresh enable
  logic                  ref_mode_reg;     // self-refresh select
  logic                  cke_reg;          // CKE control
  logic [12:0]           ref_cnt_reg;      // refresh interval
  logic [1:0]            wait_sel_reg;     // wait sample select
  logic                  endian_reg;       // strap copy
  logic                  strap_done_reg;   // strap captured
  logic [12:0]           tick_reg;         // refresh counter
  logic [2:0]            wait_sync_reg;    // pin synchroniser
  logic [2:0]            strap_sync_reg;   // strap synchroniser
  logic                  wait_level_reg;   // wait level, flops two and three agree
  logic                  hit;              // address decoded
  logic                  wr_go;            // write takes effect
  logic                  sdram_hit;        // SDRAM access strobe active
  logic [31:0]           wmask;            // byte lane mask
  logic [31:0]           cur;              // current register image
  logic [31:0]           nxt;              // merged write value
  logic                  sample;           // wait sample pulse
  logic                  waiting;          // wait seen low
  ebr_pkg::ebr_access_t  acc;              // access bundle
  ebr_pkg::ebr_lanes_t   lanes_next;       // next pin values

  assign acc = '{strobe: acc_strobe_i, is_sdram: acc_sdram_i, is_write: acc_write_i, lanes: acc_lanes_i};
  assign hit = wb_adr_i == ebr_pkg::CTRL_OFFSET;
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !wb_err_o && hit;
  assign sdram_hit = acc.strobe && acc.is_sdram;

  // byte-select mask, one lane per generate pass
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sel
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // register image, reserved bits zero
  always_comb begin
    cur = 32'h0000_0000;
    cur[ebr_pkg::LANE_MODE_BIT] = lane_mode_reg;
    cur[ebr_pkg::REF_EN_BIT] = ref_en_reg;
    cur[ebr_pkg::REF_MODE_BIT] = ref_mode_reg;
    cur[ebr_pkg::CKE_BIT] = cke_reg;
    cur[ebr_pkg::REF_CNT_LSB +: ebr_pkg::REF_CNT_W] = ref_cnt_reg;
    cur[ebr_pkg::WAIT_SEL_LSB +: 2] = wait_sel_reg;
    cur[ebr_pkg::ENDIAN_BIT] = endian_reg;
    nxt = (cur & ~(wmask & ebr_pkg::WRITE_MASK)) | (wb_dat_i & wmask & ebr_pkg::WRITE_MASK);
  end

  ////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after strobe, err if unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
      wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
      wb_dat_o <= hit ? cur : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////
  // writable fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_mode_reg <= ebr_pkg::CTRL_RESET[ebr_pkg::LANE_MODE_BIT];
      ref_en_reg    <= ebr_pkg::CTRL_RESET[ebr_pkg::REF_EN_BIT];
      cke_reg       <= ebr_pkg::CTRL_RESET[ebr_pkg::CKE_BIT];
      ref_cnt_reg   <= ebr_pkg::CTRL_RESET[ebr_pkg::REF_CNT_LSB +: ebr_pkg::REF_CNT_W];
      wait_sel_reg  <= ebr_pkg::CTRL_RESET[ebr_pkg::WAIT_SEL_LSB +: 2];
    end else if (wr_go) begin
      lane_mode_reg <= nxt[ebr_pkg::LANE_MODE_BIT];
      ref_en_reg    <= nxt[ebr_pkg::REF_EN_BIT];
      cke_reg       <= nxt[ebr_pkg::CKE_BIT];
      ref_cnt_reg   <= nxt[ebr_pkg::REF_CNT_LSB +: ebr_pkg::REF_CNT_W];
      wait_sel_reg  <= nxt[ebr_pkg::WAIT_SEL_LSB +: 2];
    end
  end

  // self-refresh bit: software sets, SDRAM access clears (clear wins)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_mode_reg <= ebr_pkg::CTRL_RESET[ebr_pkg::REF_MODE_BIT];
    end else if (sdram_hit) begin
      ref_mode_reg <= 1'b0;
    end else if (wr_go) begin
      ref_mode_reg <= nxt[ebr_pkg::REF_MODE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////
  // strap capture after reset release, via three flops
  // strap flops run through reset, so the pin level is already in them at release
  always_ff @(posedge clk_i) begin
    strap_sync_reg <= {strap_sync_reg[1:0], endian_strap_line_i};
  end

  // wait pin flops, idle high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_sync_reg <= 3'h7;
    end else begin
      wait_sync_reg <= {wait_sync_reg[1:0], ext_wait_request_n_i};
    end
  end

  // wait level only moves once second and third flop agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_level_reg <= 1'b1;
    end else if (wait_sync_reg[2] == wait_sync_reg[1]) begin
      wait_level_reg <= wait_sync_reg[2];
    end
  end

  // catch strap once second and third flop agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endian_reg     <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg && strap_sync_reg[2] == strap_sync_reg[1]) begin
      endian_reg     <= strap_sync_reg[2];
      strap_done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // refresh interval counter, pulse when count elapses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg      <= 13'h0000;
      refresh_req_o <= 1'b0;
    end else if (!ref_en_reg || ref_mode_reg || ref_cnt_reg == 13'h0000) begin
      tick_reg      <= 13'h0000;
      refresh_req_o <= 1'b0;
    end else if (tick_reg >= ref_cnt_reg - 13'h0001) begin
      tick_reg      <= 13'h0000;
      refresh_req_o <= 1'b1;
    end else begin
      tick_reg      <= tick_reg + 13'h0001;
      refresh_req_o <= 1'b0;
    end
  end

  // SDRAM power state outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdram_cke_o    <= 1'b1;
      self_refresh_o <= 1'b0;
    end else begin
      sdram_cke_o    <= cke_reg && !(ref_mode_reg && !sdram_hit);
      self_refresh_o <= ref_mode_reg && !sdram_hit;
    end
  end

  ////////////////////////////////////////////////////////////
  // byte lane pins for bank 0
  always_comb begin
    lanes_next = '{lane_n: 2'h3, we_n: 1'b1};
    if (acc.strobe && !acc.is_sdram) begin
      if (lane_mode_reg) begin
        lanes_next.lane_n = ~acc.lanes;
        lanes_next.we_n   = !acc.is_write;
      end else begin
        lanes_next.lane_n = acc.is_write ? ~acc.lanes : 2'h3;
        lanes_next.we_n   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_lane_strobe_n_o <= 2'h3;
      write_strobe_n_o     <= 1'b1;
    end else begin
      byte_lane_strobe_n_o <= lanes_next.lane_n;
      write_strobe_n_o     <= lanes_next.we_n;
    end
  end

  ////////////////////////////////////////////////////////////
  // wait sampling
  ebr_wait_sampler u_wait (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .strobe_i   (acc.strobe),
    .wait_sel_i (wait_sel_reg),
    .wait_n_i   (wait_level_reg),
    .sample_o   (sample),
    .waiting_o  (waiting)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_stall_o <= 1'b0;
    end else begin
      wait_stall_o <= waiting || (sample && !wait_level_reg);
    end
  end

  ////////////////////////////////////////////////////////////
  // checks
  sequence refresh_armed_s;
    ref_en_reg && !ref_mode_reg && ref_cnt_reg == 13'h0005;
  endsequence

  lane_strobe_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_strobe_i && !acc_sdram_i && !lane_mode_reg && !acc_write_i |=> byte_lane_strobe_n_o == 2'h3)
    else $error("lane strobe active on read in strobe mode");
  lane_enable_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_strobe_i && !acc_sdram_i && lane_mode_reg |=> write_strobe_n_o == !$past(acc_write_i))
    else $error("write strobe wrong in enable mode");
  refresh_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ref_en_reg ##1 !ref_en_reg |-> !refresh_req_o)
    else $error("refresh issued while disabled");
  self_refresh_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_mode_reg && !sdram_hit |=> self_refresh_o && !sdram_cke_o)
    else $error("self-refresh not entered");
  access_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sdram_hit |=> !ref_mode_reg)
    else $error("mode bit not cleared by access");
  cke_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ref_mode_reg |=> sdram_cke_o == $past(cke_reg))
    else $error("cke does not follow control bit");
  refresh_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refresh_armed_s and refresh_req_o ##1 refresh_armed_s [*5] |-> refresh_req_o)
    else $error("refresh period wrong");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> (wb_dat_o & 32'hFEF8_0000) == 32'h0000_0000)
    else $error("reserved bits read nonzero");
  strap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strap_done_reg |=> $stable(endian_reg))
    else $error("endian bit changed after capture");
endmodule

// ==== bench/ebr_ext_model.sv ====
// model of the external SDRAM and I/O devices on the far side
`timescale 1ns/1ns
module ebr_ext_model (
  input  wire logic clk_i,          // system clock
  input  wire logic hold_wait_i,    // bench asks device to stall
  input  wire logic self_refresh_i, // self-refresh request
  input  wire logic sdram_cke_i,    // sdram clock enable
  output logic      ext_wait_n_o,   // wait request pin
  output logic      strap_o,        // endian strap line
  output logic      in_self_o       // sdram held in self-refresh
);
  // strap resistor is a pull-up: little-endian
  assign strap_o = 1'b1;
  // wait line has a pull-up, low only on request
  assign ext_wait_n_o = ~hold_wait_i;
  // device state: enters self-refresh with cke low
  always_ff @(posedge clk_i) begin
    in_self_o <= self_refresh_i & ~sdram_cke_i;
  end
endmodule

// ==== bench/ebr_ctrl_tb.sv ====
// testbench for the external bus refresh control block
`timescale 1ns/1ns
module ebr_ctrl_tb;
  logic        clk_i, rst_i;         // clock and reset
  logic        cyc, stb, we;         // bus request
  logic [7:0]  adr;                  // bus address
  logic [31:0] wdat, rdat, rd;       // bus data
  logic        ack, err, er;         // bus answers
  logic        a_stb, a_sd, a_wr;    // access side
  logic [1:0]  a_ln, ln_n;           // lanes in and lane pins
  logic        we_n, cke, rreq;      // pin outputs
  logic        selfr, stall;         // refresh and wait state
  logic        hold_w, wait_n;       // wait request
  logic        strap, in_self;       // far side
  int          n_fail, checked, k, c1;
  int          wc[4];                // cycles to stall per select

  ebr_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .acc_strobe_i(a_stb), .acc_sdram_i(a_sd), .acc_write_i(a_wr),
    .acc_lanes_i(a_ln), .ext_wait_request_n_i(wait_n), .endian_strap_line_i(strap),
    .byte_lane_strobe_n_o(ln_n), .write_strobe_n_o(we_n), .sdram_cke_o(cke),
    .refresh_req_o(rreq), .self_refresh_o(selfr), .wait_stall_o(stall));
  ebr_ext_model ext (.clk_i(clk_i), .hold_wait_i(hold_w), .self_refresh_i(selfr),
    .sdram_cke_i(cke), .ext_wait_n_o(wait_n), .strap_o(strap), .in_self_o(in_self));

  ////////////////////////////////////////////////////////////////
  // clock, 8 ns period
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end

  // compare and report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic wishbone cycle, waits for ack or err
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack | err) break;
    end
    if (k == 20) begin
      n_fail++;
      $display("CHECK FAILED bus answer expected 1 seen 0");
    end
    q = rdat;
    e = err;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  // register write and checked read
  task automatic wr(input logic [31:0] d);
    bus(1, 8'h00, d, rd, er);
  endtask
  task automatic rdchk(input logic [31:0] e);
    bus(0, 8'h00, 32'h0000_0000, rd, er);
    chk("ctrl", e, rd);
  endtask

  // external access, pins settled on return
  task automatic acc(input logic sd, input logic w, input logic [1:0] l);
    @(posedge clk_i);
    a_stb <= 1;
    a_sd <= sd;
    a_wr <= w;
    a_ln <= l;
    repeat (2) @(posedge clk_i);
    a_stb <= 0;
  endtask

  // refresh pulses seen in 50 clocks
  task automatic cnt_ref(output int n);
    n = 0;
    repeat (50) begin
      @(posedge clk_i);
      n += int'(rreq === 1'b1);
    end
  endtask

  // clocks from strobe rise to stall, 20 when none
  task automatic wt(input logic [1:0] s, output int n);
    wr(32'h0001_0000 | {29'h0, s, 1'b0});
    repeat (6) @(posedge clk_i);
    a_stb <= 1;
    @(posedge clk_i);
    n = 1;
    while (stall !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    a_stb <= 0;
    repeat (6) @(posedge clk_i);
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #300000;
    n_fail++;
    complete_run;
  end

  // main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    {rst_i, cyc, stb, we, adr, wdat} = {1'b1, 43'h0};
    {a_stb, a_sd, a_wr, a_ln, hold_w} = 6'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    repeat (5) @(posedge clk_i);
    rdchk(32'h0001_0001);
    chk("cke", 1, cke);
    bus(0, 8'h04, 32'h0000_0000, rd, er);
    chk("err", 1, er);
    // reserved bits and bit 0 ignored, self-refresh entered
    wr(32'hFFFF_FFFF);
    rdchk(32'h0107_FFFF);
    chk("self", 1, selfr);
    chk("cke", 0, cke);
    chk("device self", 1, in_self);
    // sdram write in enable mode leaves self-refresh
    acc(1, 1, 2'b01);
    chk("sdram lanes", 2'b11, ln_n);
    chk("sdram we_n", 1, we_n);
    rdchk(32'h0105_FFFF);
    chk("self", 0, selfr);
    // bank-0 write and read with lanes as enables
    acc(0, 1, 2'b01);
    chk("lanes", 2'b10, ln_n);
    chk("we_n", 0, we_n);
    acc(0, 0, 2'b10);
    chk("lanes rd en", 2'b01, ln_n);
    chk("we_n rd", 1, we_n);
    // auto-refresh every 5 clocks, strobe lane mode
    wr(32'h0005_0028);
    cnt_ref(c1);
    chk("refs", 10, c1);
    acc(0, 1, 2'b10);
    chk("lanes", 2'b01, ln_n);
    acc(0, 0, 2'b11);
    chk("lanes rd", 2'b11, ln_n);
    wr(32'h0000_0028);
    cnt_ref(c1);
    chk("refs", 0, c1);
    chk("cke", 0, cke);
    // wait sample cycle for every select code
    hold_w <= 1;
    for (int s = 0; s < 4; s++) begin
      wt(s[1:0], wc[s]);
    end
    chk("wait off", 20, wc[0]);
    chk("wait n2", 4, wc[1]);
    chk("wait n3", wc[1] + 1, wc[2]);
    chk("wait n4", wc[1] + 2, wc[3]);
    hold_w <= 0;
    wt(2'b11, c1);
    chk("wait high", 20, c1);
    complete_run;
  end
endmodule
